/* File: hdl/pfmc_pkg.sv */
// package: register map, field layout and types for the pin function mux
package pfmc_pkg;
  localparam int NUM_PINS = 7;
  localparam logic [31:0] BASE_ADDR = 32'h4042_8000;
  // register addresses, in pin order
  localparam logic [31:0] ADDR_PIN_CTRL_1 = 32'h4042_8000;
  localparam logic [31:0] ADDR_PIN_CTRL_2 = 32'h4042_8004;
  localparam logic [31:0] ADDR_PIN_CTRL_5 = 32'h4042_8010;
  localparam logic [31:0] ADDR_PIN_CTRL_6 = 32'h4042_8014;
  localparam logic [31:0] ADDR_PIN_CTRL_7 = 32'h4042_8018;
  localparam logic [31:0] ADDR_PIN_CTRL_8 = 32'h4042_801c;
  localparam logic [31:0] ADDR_PIN_CTRL_9 = 32'h4042_8020;
  // field positions
  localparam int FSEL_LSB = 0;
  localparam int FSEL_W = 6;
  localparam int CONN_BIT = 7;
  localparam int PDN_BIT = 16;
  localparam int PUP_BIT = 17;
  localparam int HYST_BIT = 25;
  localparam int INV_BIT = 26;
  localparam int WAKE_EN_BIT = 27;
  localparam int WAKE_POL_BIT = 28;
  localparam int NUM_FUNCS = 15;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // writable bits per buffer type
  localparam logic [31:0] MASK_STD = 32'h0403_00bf;
  localparam logic [31:0] MASK_STD_WAKE = 32'h1c03_00bf;
  localparam logic [31:0] MASK_OPEN_DRAIN_TOLERANT_BUFFER = 32'h1e01_00bf;
  // buffer type codes, one-hot
  typedef enum logic [2:0] {
    PFMC_BUF_STD = 3'b001,
    PFMC_BUF_STD_WAKE = 3'b010,
    PFMC_BUF_OPEN_DRAIN_TOLERANT_BUFFER = 3'b100
  } pfmc_buf_t;
  // decoded pad controls for one pin
  typedef struct packed {
    logic pull_up;
    logic pull_down;
    logic hyst;
    logic invert;
  } pfmc_pad_t;
endpackage

/* File: hdl/pfmc_regfile.sv */
// small register store holding the pin control words, registered read port
`timescale 1ns/1ps
`default_nettype none
module pfmc_regfile (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic [2:0] rd_idx,
  output logic [31:0] rd_data,
  output logic [pfmc_pkg::NUM_PINS*32-1:0] all_words
);
  logic [31:0] mem [pfmc_pkg::NUM_PINS];
  genvar g;
  // one word per pin, cleared by reset
  generate
    for (g = 0; g < pfmc_pkg::NUM_PINS; g++) begin : g_word
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          mem[g] <= pfmc_pkg::CTRL_RESET;
        end else if (wr_en && wr_idx == 3'(g)) begin
          mem[g] <= wr_data;
        end
      end
      assign all_words[g*32 +: 32] = mem[g];
    end
  endgenerate
  // read data registered, stands one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_idx < 3'(pfmc_pkg::NUM_PINS)) begin
      rd_data <= mem[rd_idx];
    end else begin
      rd_data <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/pfmc_top.sv */
// pin function mux: per-pin control words, function select and pad features
// Summary of operation
// - each digital pin owns one control word with a function-select field
// - at most one muxed digital function reaches a pin at a time
// - analog and wake signals stay attached while a muxed function runs
// - open-drain tolerant pins: invert, hysteresis, pull-down, wake, no pull-up
// - wake standard pins: invert, pulls, wake; plain standard: same, no wake
// - wake-capable pins can leave the deepest sleep state on a wake event
// - any wake-capable pin can wake the device from the lighter sleep states; plain standard pins cannot
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pfmc_top (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire logic [pfmc_pkg::NUM_PINS*pfmc_pkg::NUM_FUNCS-1:0] func_out,
  input wire logic [pfmc_pkg::NUM_PINS*pfmc_pkg::NUM_FUNCS-1:0] func_oe,
  output logic [pfmc_pkg::NUM_PINS*pfmc_pkg::NUM_FUNCS-1:0] func_in,
  input wire logic [pfmc_pkg::NUM_PINS-1:0] pad_in,
  output logic [pfmc_pkg::NUM_PINS-1:0] pad_out,
  output logic [pfmc_pkg::NUM_PINS-1:0] pad_oe_n,
  output logic [pfmc_pkg::NUM_PINS*4-1:0] pad_ctrl,
  output logic [pfmc_pkg::NUM_PINS-1:0] pad_raw,
  input wire logic in_deep_sleep,
  input wire logic in_light_sleep,
  output logic wake_deep,
  output logic wake_light
);
  localparam int NP = pfmc_pkg::NUM_PINS;
  localparam int NF = pfmc_pkg::NUM_FUNCS;

  // buffer type of each pin, in register order
  function automatic pfmc_pkg::pfmc_buf_t buf_of(input int idx);
    case (idx)
      0: buf_of = pfmc_pkg::PFMC_BUF_OPEN_DRAIN_TOLERANT_BUFFER;
      1: buf_of = pfmc_pkg::PFMC_BUF_OPEN_DRAIN_TOLERANT_BUFFER;
      default: buf_of = pfmc_pkg::PFMC_BUF_STD;
    endcase
  endfunction

  // writable mask per buffer type; absent features read as zero
  function automatic logic [31:0] mask_of(input pfmc_pkg::pfmc_buf_t b);
    case (b)
      pfmc_pkg::PFMC_BUF_OPEN_DRAIN_TOLERANT_BUFFER: mask_of = pfmc_pkg::MASK_OPEN_DRAIN_TOLERANT_BUFFER;
      pfmc_pkg::PFMC_BUF_STD_WAKE: mask_of = pfmc_pkg::MASK_STD_WAKE;
      pfmc_pkg::PFMC_BUF_STD: mask_of = pfmc_pkg::MASK_STD;
      default: mask_of = pfmc_pkg::MASK_STD;
    endcase
  endfunction

  // address to pin index; NP means unmapped
  function automatic logic [2:0] idx_of(input logic [31:0] a);
    case (a)
      pfmc_pkg::ADDR_PIN_CTRL_1: idx_of = 3'd0;
      pfmc_pkg::ADDR_PIN_CTRL_2: idx_of = 3'd1;
      pfmc_pkg::ADDR_PIN_CTRL_5: idx_of = 3'd2;
      pfmc_pkg::ADDR_PIN_CTRL_6: idx_of = 3'd3;
      pfmc_pkg::ADDR_PIN_CTRL_7: idx_of = 3'd4;
      pfmc_pkg::ADDR_PIN_CTRL_8: idx_of = 3'd5;
      pfmc_pkg::ADDR_PIN_CTRL_9: idx_of = 3'd6;
      default: idx_of = 3'(NP);
    endcase
  endfunction

  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic [31:0] wr_mask;
  logic [31:0] rd_word;
  logic [NP*32-1:0] words;

  // decode and mask the write: unmapped writes are dropped
  always_comb begin
    wr_idx = idx_of(addr);
    rd_idx = rd_stb ? idx_of(addr) : 3'(NP);
    wr_mask = 32'h0000_0000;
    for (int i = 0; i < NP; i++) begin
      if (wr_idx == 3'(i)) begin
        wr_mask = mask_of(buf_of(i));
      end
    end
  end

  pfmc_regfile u_regs (
    .ref_clk(ref_clk),
    .reset(reset),
    .wr_en(wr_stb && wr_idx < 3'(NP)),
    .wr_idx(wr_idx),
    .wr_data(wdata & wr_mask),
    .rd_idx(rd_idx),
    .rd_data(rd_word),
    .all_words(words)
  );

  // read data come straight from the store's output register
  assign rdata = rd_word;

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_pin
      logic [31:0] w;
      logic [pfmc_pkg::FSEL_W-1:0] fsel;
      logic conn;
      logic sel_ok;
      logic [3:0] fidx;
      logic in_val;
      logic wake_prev;
      assign w = words[g*32 +: 32];
      assign fsel = w[pfmc_pkg::FSEL_LSB +: pfmc_pkg::FSEL_W];
      assign conn = w[pfmc_pkg::CONN_BIT];
      // zero or out-of-range select means no function
      assign sel_ok = fsel != '0 && fsel <= pfmc_pkg::FSEL_W'(NF);
      assign fidx = 4'(fsel - 1'b1);
      assign in_val = pad_in[g] ^ w[pfmc_pkg::INV_BIT];

      // single selected function drives the pad
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          pad_out[g] <= 1'b0;
          pad_oe_n[g] <= 1'b1;
        end else if (sel_ok) begin
          pad_out[g] <= func_out[g*NF + fidx] ^ w[pfmc_pkg::INV_BIT];
          pad_oe_n[g] <= ~func_oe[g*NF + fidx];
        end else begin
          pad_out[g] <= 1'b0;
          pad_oe_n[g] <= 1'b1;
        end
      end

      // input routed only to the selected function, gated by connect
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          func_in[g*NF +: NF] <= '0;
        end else begin
          for (int f = 0; f < NF; f++) begin
            func_in[g*NF + f] <= sel_ok && conn && fidx == 4'(f) && in_val;
          end
        end
      end

      // raw pad level stays visible to analog/wake whatever the select
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          pad_raw[g] <= 1'b0;
        end else begin
          pad_raw[g] <= pad_in[g];
        end
      end

      // pad features masked by buffer type
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          pad_ctrl[g*4 +: 4] <= '0;
        end else begin
          pad_ctrl[g*4 +: 4] <= {w[pfmc_pkg::PUP_BIT], w[pfmc_pkg::PDN_BIT],
                                 w[pfmc_pkg::HYST_BIT], w[pfmc_pkg::INV_BIT]};
        end
      end

      // wake event: level match on the configured polarity
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          wake_prev <= 1'b0;
        end else begin
          wake_prev <= w[pfmc_pkg::WAKE_EN_BIT] &&
                       (pad_in[g] == w[pfmc_pkg::WAKE_POL_BIT]);
        end
      end
    end
  endgenerate

  logic [NP-1:0] wake_hit;
  logic [NP-1:0] deep_ok;
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      wake_hit[i] = g_pin[0].wake_prev;
      deep_ok[i] = 1'b0;
    end
    wake_hit[0] = g_pin[0].wake_prev;
    wake_hit[1] = g_pin[1].wake_prev;
    wake_hit[2] = g_pin[2].wake_prev;
    wake_hit[3] = g_pin[3].wake_prev;
    wake_hit[4] = g_pin[4].wake_prev;
    wake_hit[5] = g_pin[5].wake_prev;
    wake_hit[6] = g_pin[6].wake_prev;
    for (int i = 0; i < NP; i++) begin
      deep_ok[i] = buf_of(i) != pfmc_pkg::PFMC_BUF_STD;
    end
  end

  // deep wake only from wake-capable buffers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wake_deep <= 1'b0;
    end else begin
      wake_deep <= in_deep_sleep && |(wake_hit & deep_ok);
    end
  end

  // any wake-enabled pin wakes from lighter sleep states; standard pins have no writable wake enable
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wake_light <= 1'b0;
    end else begin
      wake_light <= in_light_sleep && |wake_hit;
    end
  end

  // open-drain pin never keeps a pull-up
  no_pullup_a: assert property (@(posedge ref_clk) disable iff (reset)
    !pad_ctrl[3] && !pad_ctrl[7]) else $error("pull-up on open-drain pin");
  // zero select keeps the pad undriven next cycle
  zero_sel_a: assert property (@(posedge ref_clk) disable iff (reset)
    (g_pin[2].fsel == '0) |=> pad_oe_n[2]) else $error("pad driven with no select");
  // at most one function input active on pin 2
  one_func_a: assert property (@(posedge ref_clk) disable iff (reset)
    $onehot0(func_in[2*NF +: NF])) else $error("two functions on one pin");
  // plain pin never wakes deep sleep
  deep_wake_a: assert property (@(posedge ref_clk) disable iff (reset)
    (in_deep_sleep && !(g_pin[0].wake_prev || g_pin[1].wake_prev)) |=> !wake_deep)
    else $error("deep wake from plain pin");
  // light wake follows a wake hit by one cycle
  light_wake_a: assert property (@(posedge ref_clk) disable iff (reset)
    (in_light_sleep && g_pin[3].wake_prev) |=> wake_light)
    else $error("light wake missed");
  rd_back_a: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_stb && addr == pfmc_pkg::ADDR_PIN_CTRL_5 && !$isunknown(wdata)) ##1
    (rd_stb && addr == pfmc_pkg::ADDR_PIN_CTRL_5) |=>
    rdata == ($past(wdata, 2) & pfmc_pkg::MASK_STD)) else $error("readback mismatch");
  // raw pad follows input whatever the select
  raw_pad_a: assert property (@(posedge ref_clk) disable iff (reset)
    1'b1 |=> pad_raw[4] == $past(pad_in[4])) else $error("raw pad lost");
  std_hyst_a: assert property (@(posedge ref_clk) disable iff (reset)
    !pad_ctrl[2*4+1]) else $error("hysteresis on standard pin");
  unmap_rd_a: assert property (@(posedge ref_clk) disable iff (reset)
    (rd_stb && idx_of(addr) == 3'(NP)) |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  cov_deep_c: cover property (@(posedge ref_clk) wake_deep);
  cov_light_c: cover property (@(posedge ref_clk) wake_light);
  cov_drive_c: cover property (@(posedge ref_clk) !pad_oe_n[2]);
  cov_func_c: cover property (@(posedge ref_clk) |func_in);
endmodule
`default_nettype wire

/* File: verification/pfmc_top_tb.sv */
// self-checking bench for the pin function mux: registers, mux paths, pads, wake
`timescale 1ns/1ps
`default_nettype none
module pfmc_top_tb;
  localparam int NP = pfmc_pkg::NUM_PINS;
  localparam int NF = pfmc_pkg::NUM_FUNCS;
  localparam int W = NP * NF;
  localparam logic [31:0] CONN = 32'h0000_0080;
  localparam logic [31:0] WAKE = 32'h1800_0000;
  logic ref_clk, reset, wr_stb, rd_stb, in_deep_sleep, in_light_sleep, wake_deep, wake_light;
  logic [31:0] addr, wdata, rdata, got, m;
  logic [W-1:0] func_out, func_oe, func_in;
  logic [NP-1:0] pad_in, pad_out, pad_oe_n, pad_raw;
  logic [NP*4-1:0] pad_ctrl;
  logic [31:0] addrs [NP];
  int fails, num_checks, b;
  int sels [3] = '{1, 8, 15};
  int bad [2] = '{0, 16};

  pfmc_top u_dut (.ref_clk, .reset, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .func_out,
    .func_oe, .func_in, .pad_in, .pad_out, .pad_oe_n, .pad_ctrl, .pad_raw,
    .in_deep_sleep, .in_light_sleep, .wake_deep, .wake_light);

  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // each access syncs to the next edge, so strobes never get two values in one step
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 got = rdata;
    chk(W'(got), W'(exp), what);
  endtask

  // pad and function outputs are two flops behind a write, wake outputs three; four edges leaves margin, sampled off-edge
  task automatic settle;
    repeat (4) @(posedge ref_clk);
    #2;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // watchdog: the sequence needs roughly three hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    complete_run();
  end

  initial begin
    addrs = '{pfmc_pkg::ADDR_PIN_CTRL_1, pfmc_pkg::ADDR_PIN_CTRL_2, pfmc_pkg::ADDR_PIN_CTRL_5,
      pfmc_pkg::ADDR_PIN_CTRL_6, pfmc_pkg::ADDR_PIN_CTRL_7, pfmc_pkg::ADDR_PIN_CTRL_8,
      pfmc_pkg::ADDR_PIN_CTRL_9};
    reset = 1'b1;
    {wr_stb, rd_stb, in_deep_sleep, in_light_sleep} = 4'h0;
    addr = 32'h0000_0000;
    wdata = 32'h0000_0000;
    func_out = '0;
    func_oe = '0;
    pad_in = '0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    #2;
    chk(W'({pad_oe_n, pad_out, wake_deep, wake_light}), W'({7'h7f, 7'h00, 2'b00}), "reset pads");
    // one word per pin, features by buffer type
    for (int p = 0; p < NP; p++) begin
      m = (p < 2) ? pfmc_pkg::MASK_OPEN_DRAIN_TOLERANT_BUFFER : pfmc_pkg::MASK_STD;
      rchk(addrs[p], pfmc_pkg::CTRL_RESET, "reset word");
      wr(addrs[p], 32'hffff_ffff);
      rchk(addrs[p], m, "writable bits");
      chk(W'(pad_ctrl[p*4 +: 4]), W'({m[pfmc_pkg::PUP_BIT], m[pfmc_pkg::PDN_BIT],
        m[pfmc_pkg::HYST_BIT], m[pfmc_pkg::INV_BIT]}), "pad features");
      wr(addrs[p], 32'h0000_0000);
    end
    // a hole in the map neither stores nor aliases onto a pin word
    wr(32'h4042_800c, 32'hffff_ffff);
    rchk(32'h4042_800c, 32'h0000_0000, "unmapped read");
    rchk(addrs[1], 32'h0000_0000, "no alias");
    // only the selected function reaches the pin
    for (int p = 0; p < NP; p += 3) begin
      foreach (sels[i]) begin
        b = p * NF + sels[i] - 1;
        wr(addrs[p], CONN | 32'(sels[i]));
        @(posedge ref_clk);
        func_out <= W'(1) << b;
        func_oe <= W'(1) << b;
        pad_in <= NP'(1) << p;
        settle();
        chk(W'({pad_out[p], pad_oe_n[p]}), W'(2'b10), "selected drives");
        chk(func_in, W'(1) << b, "selected input");
        @(posedge ref_clk);
        func_out <= ~(W'(1) << b);
        func_oe <= ~(W'(1) << b);
        settle();
        chk(W'({pad_out[p], pad_oe_n[p]}), W'(2'b01), "others isolated");
        wr(addrs[p], 32'(sels[i]));
        settle();
        chk(func_in, '0, "connect off");
      end
      foreach (bad[i]) begin
        wr(addrs[p], CONN | 32'(bad[i]));
        @(posedge ref_clk);
        func_out <= '1;
        func_oe <= '1;
        settle();
        chk(W'({pad_oe_n[p], pad_out[p]}), W'(2'b10), "no function pad");
        chk(func_in, '0, "no function input");
      end
      wr(addrs[p], 32'h0000_0000);
    end
    // inversion on the input path, raw pad level kept alongside
    wr(addrs[0], CONN | 32'h0400_0001);
    @(posedge ref_clk);
    pad_in <= 7'h54;
    settle();
    chk(func_in, W'(1), "inverted input");
    // func_oe is still all ones, so pin 0 also drives its pad here; the raw path samples pad_in only
    chk(W'(pad_raw), W'(7'h54), "raw alongside");
    // select and connect zeroed when the pin goes back to analog use
    wr(addrs[0], 32'h0000_0000);
    // deep wake only from a wake-capable pin, level matched
    wr(addrs[0], WAKE);
    wr(addrs[2], WAKE);
    @(posedge ref_clk);
    in_deep_sleep <= 1'b1;
    pad_in <= 7'h04;
    settle();
    chk(W'(wake_deep), W'(0), "plain pin no wake");
    @(posedge ref_clk);
    pad_in <= 7'h01;
    settle();
    chk(W'(wake_deep), W'(1), "deep wake");
    // lighter sleep, low-level polarity on the second pin; first pin's wake dropped
    wr(addrs[0], 32'h0000_0000);
    @(posedge ref_clk);
    in_deep_sleep <= 1'b0;
    in_light_sleep <= 1'b1;
    pad_in <= 7'h7d;
    settle();
    chk(W'({wake_deep, wake_light}), W'(2'b00), "no wake yet");
    wr(addrs[1], 32'h0800_0000);
    settle();
    chk(W'(wake_light), W'(1), "light wake");
    complete_run();
  end
endmodule
`default_nettype wire
